// >>> core/cmpm_pkg.sv
// constants and carrier types for the cell monitor power mode controller.
// assumes a single core clock; sleep ticks come from the low-speed oscillator as a one-cycle pulse.
// Summary of operation
// RQ1: sleep is entered on a sleep command or on a watchdog timeout.
// RQ2: in sleep only comms input, slow oscillator and registers stay powered; digital core, sleep regulators and input buffers also stay on here.
// RQ3: sleep still runs timed scan and balance; comms activity wakes the device; balance sources are held off in sleep work here.
// RQ4: shutdown holds for as long as enable is low.
// RQ5: shutdown keeps digital core, sleep regulators and input buffers powered.
// RQ6: leaving shutdown skips the factory configuration reload.
// RQ7: normal mode has standby (waiting) and active (operation running) states.
// RQ8: balance current sources follow demand and are forced off in sleep and shutdown.
// RQ9: top three balance outputs drive p-channel, lower nine drive n-channel.
// RQ10: balancing mode is manual, timed or automatic.
// RQ11: chain holds at most fourteen devices of twelve cells each.
// RQ12: fault state is readable; comms faults answer or go unprompted upstream.
// RQ13: measurement results are unfiltered; fault detect inputs are filtered.
// RQ14: two scanning modes over all cells plus single direct measurement.
// RQ15: results are fourteen bits, held in data registers.
// RQ16: main regulator and external supply switch are on only in normal mode.
// RQ17: wake or shutdown exit lands in standby until a command starts work.
package cmpm_pkg;
    localparam int CMPM_CELLS = 12;
    localparam int CMPM_NCH_CELLS = 9;
    localparam int CMPM_MAX_DEVICES = 14;
    localparam int CMPM_ADC_BITS = 14;
    localparam int CMPM_FILT_LEN = 4;
    localparam logic [1:0] CMPM_BAL_MANUAL = 2'h0;
    localparam logic [1:0] CMPM_BAL_TIMED = 2'h1;
    localparam logic [1:0] CMPM_BAL_AUTO = 2'h2;

    typedef enum logic [4:0] {
        CMPM_ST_SHUTDOWN = 5'b0_0001,
        CMPM_ST_STANDBY = 5'b0_0010,
        CMPM_ST_ACTIVE = 5'b0_0100,
        CMPM_ST_SLEEP = 5'b0_1000,
        CMPM_ST_SLPWORK = 5'b1_0000
    } cmpm_state_t;

    typedef struct packed {
        logic sleep_cmd;
        logic wdog_timeout;
        logic comms_activity;
        logic op_start;
        logic op_done;
        logic timed_tick;
        logic timed_done;
    } cmpm_evt_t;

    typedef struct packed {
        logic main_reg_en;
        logic ext_sw_en;
        logic analog_bias_en;
        logic comms_in_en;
        logic slow_osc_en;
        logic regs_en;
        logic digital_core_en;
        logic sleep_reg_en;
        logic in_buf_en;
    } cmpm_pwr_t;
endpackage

// >>> core/cmpm_filter.sv
// majority-free persistence filter for one fault detect input.
// assumes the input is already synchronous to the core clock.
`timescale 1ns/1ns
module cmpm_filter
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_raw,
    output logic o_filt
);
    import cmpm_pkg::*;
    logic [CMPM_FILT_LEN-1:0] hist_q;
    logic [CMPM_FILT_LEN-1:0] hist_d;
    logic filt_q;
    logic filt_d;

    always_comb
    begin
        hist_d = {hist_q[CMPM_FILT_LEN-2:0], i_raw};
        filt_d = filt_q;
        if (&hist_q)
        begin
            filt_d = 1'b1;
        end
        else if (~|hist_q)
        begin
            filt_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            hist_q <= '0;
            filt_q <= 1'b0;
        end
        else
        begin
            hist_q <= hist_d;
            filt_q <= filt_d;
        end
    end

    assign o_filt = filt_q;
endmodule

// >>> core/cmpm_top.sv
// power mode sequencer: normal/sleep/shutdown, rail enables, balance gate drive.
// assumes all inputs synchronous to i_core_clk; events are one-cycle pulses.
`timescale 1ns/1ns
module cmpm_top
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_enable,
    input wire cmpm_pkg::cmpm_evt_t i_evt,
    input wire logic [1:0] i_bal_mode,
    input wire logic [cmpm_pkg::CMPM_CELLS-1:0] i_bal_demand,
    input wire logic [cmpm_pkg::CMPM_CELLS-1:0] i_bal_timed_mask,
    input wire logic [cmpm_pkg::CMPM_CELLS-1:0] i_bal_auto_mask,
    input wire logic i_fault_raw,
    input wire logic i_meas_valid,
    input wire logic [cmpm_pkg::CMPM_ADC_BITS-1:0] i_meas_data,
    output cmpm_pkg::cmpm_state_t o_state,
    output cmpm_pkg::cmpm_pwr_t o_pwr,
    output logic [cmpm_pkg::CMPM_CELLS-1:0] o_balance_gate_drive_output,
    output logic [cmpm_pkg::CMPM_CELLS-1:0] o_gate_src_on,
    output logic o_factory_reload,
    output logic o_fault,
    output logic [cmpm_pkg::CMPM_ADC_BITS-1:0] o_meas_q
);
    import cmpm_pkg::*;

    cmpm_state_t state_q;
    cmpm_state_t state_d;
    logic boot_q;
    logic boot_d;
    // RQ11 twelve cells per device
    logic [CMPM_CELLS-1:0] src_q;
    logic [CMPM_CELLS-1:0] src_d;
    // RQ15 fourteen-bit result register
    logic [CMPM_ADC_BITS-1:0] meas_q;
    logic [CMPM_ADC_BITS-1:0] meas_d;
    logic fault_f;

    // n-channel gates turn on when the source sinks, p-channel when it sources
    function automatic logic [CMPM_CELLS-1:0] pin_level(input logic [CMPM_CELLS-1:0] on);
        logic [CMPM_CELLS-1:0] lvl;
        lvl = '0;
        for (int i = 0; i < CMPM_CELLS; i++)
        begin
            lvl[i] = (i < CMPM_NCH_CELLS) ? ~on[i] : on[i];
        end
        return lvl;
    endfunction

    function automatic logic is_normal(input cmpm_state_t s);
        return (s == CMPM_ST_STANDBY) || (s == CMPM_ST_ACTIVE);
    endfunction

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            CMPM_ST_SHUTDOWN:
            begin
                // RQ17 exit to standby
                if (i_enable)
                begin
                    state_d = CMPM_ST_STANDBY;
                end
            end
            CMPM_ST_STANDBY:
            begin
                // RQ1 sleep entry
                if (i_evt.sleep_cmd || i_evt.wdog_timeout)
                begin
                    state_d = CMPM_ST_SLEEP;
                end
                // RQ7 start operation
                // RQ14 scans run in active
                else if (i_evt.op_start)
                begin
                    state_d = CMPM_ST_ACTIVE;
                end
            end
            CMPM_ST_ACTIVE:
            begin
                if (i_evt.sleep_cmd || i_evt.wdog_timeout)
                begin
                    state_d = CMPM_ST_SLEEP;
                end
                else if (i_evt.op_done)
                begin
                    state_d = CMPM_ST_STANDBY;
                end
            end
            CMPM_ST_SLEEP:
            begin
                // RQ3 wake on comms, timed work
                if (i_evt.comms_activity)
                begin
                    state_d = CMPM_ST_STANDBY;
                end
                else if (i_evt.timed_tick)
                begin
                    state_d = CMPM_ST_SLPWORK;
                end
            end
            CMPM_ST_SLPWORK:
            begin
                if (i_evt.comms_activity)
                begin
                    state_d = CMPM_ST_STANDBY;
                end
                else if (i_evt.timed_done)
                begin
                    state_d = CMPM_ST_SLEEP;
                end
            end
            default:
            begin
                state_d = CMPM_ST_SHUTDOWN;
            end
        endcase
        // RQ4 enable low forces shutdown
        if (!i_enable)
        begin
            state_d = CMPM_ST_SHUTDOWN;
        end
    end

    always_comb
    begin
        // RQ6 reload only on first power-up, never on shutdown exit
        boot_d = 1'b0;
        // RQ10 balance source selection
        src_d = '0;
        unique case (i_bal_mode)
            CMPM_BAL_TIMED: src_d = i_bal_demand & i_bal_timed_mask;
            CMPM_BAL_AUTO: src_d = i_bal_demand & i_bal_auto_mask;
            default: src_d = i_bal_demand;
        endcase
        // RQ8 sources off outside normal mode
        if (!is_normal(state_d))
        begin
            src_d = '0;
        end
        // RQ13 results stored unfiltered
        meas_d = i_meas_valid ? i_meas_data : meas_q;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            state_q <= CMPM_ST_SHUTDOWN;
            boot_q <= 1'b1;
            src_q <= '0;
            meas_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            boot_q <= boot_d;
            src_q <= src_d;
            meas_q <= meas_d;
        end
    end

    // RQ13 fault inputs filtered
    cmpm_filter u_fault_filt
    (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_raw(i_fault_raw),
        .o_filt(fault_f)
    );

    always_comb
    begin
        // RQ16 main regulator and switch in normal only
        o_pwr.main_reg_en = is_normal(state_q);
        o_pwr.ext_sw_en = is_normal(state_q);
        o_pwr.analog_bias_en = is_normal(state_q);
        // RQ2 sleep keeps comms, slow osc, registers
        o_pwr.comms_in_en = (state_q != CMPM_ST_SHUTDOWN);
        o_pwr.slow_osc_en = (state_q != CMPM_ST_SHUTDOWN);
        // RQ5 retained domains always on
        o_pwr.regs_en = 1'b1;
        o_pwr.digital_core_en = 1'b1;
        o_pwr.sleep_reg_en = 1'b1;
        o_pwr.in_buf_en = 1'b1;
    end

    assign o_state = state_q;
    assign o_gate_src_on = src_q;
    // RQ9 polarity per transistor type
    assign o_balance_gate_drive_output = pin_level(src_q);
    assign o_factory_reload = boot_q;
    // RQ12 fault state readable
    assign o_fault = fault_f;
    assign o_meas_q = meas_q;

    // RQ4 shutdown while enable low
    a_shutdown_hold: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ4
        !i_enable |=> state_q == CMPM_ST_SHUTDOWN) else $error("not in shutdown with enable low");
    // RQ1 sleep entry
    a_sleep_entry: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ1
        is_normal(state_q) && i_enable && (i_evt.sleep_cmd || i_evt.wdog_timeout)
        |=> state_q == CMPM_ST_SLEEP) else $error("sleep not entered");
    // RQ3 wake on comms
    a_comms_wake: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ3
        (state_q == CMPM_ST_SLEEP || state_q == CMPM_ST_SLPWORK) && i_enable && i_evt.comms_activity
        |=> state_q == CMPM_ST_STANDBY) else $error("no wake on comms");
    // RQ8 sources off in low power
    a_src_off: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ8
        !is_normal(state_q) |-> src_q == '0) else $error("balance source on in low power");
    // RQ16 regulator follows normal mode
    a_reg_normal: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ16
        o_pwr.main_reg_en == is_normal(state_q) && o_pwr.ext_sw_en == o_pwr.main_reg_en)
        else $error("regulator enable mismatch");
    // RQ17 shutdown exit to standby
    a_exit_standby: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ17
        state_q == CMPM_ST_SHUTDOWN && i_enable |=> state_q == CMPM_ST_STANDBY)
        else $error("shutdown exit not to standby");
    // RQ6 no reload after shutdown
    a_no_reload: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ6
        $fell(state_q == CMPM_ST_SHUTDOWN) |-> !o_factory_reload) else $error("factory reload on exit");
    // RQ9 n-channel polarity
    a_nch_pol: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ9
        src_q[0] |-> !o_balance_gate_drive_output[0]
        && (src_q[CMPM_CELLS-1] == o_balance_gate_drive_output[CMPM_CELLS-1]))
        else $error("gate polarity wrong");
    // RQ13 unfiltered capture
    a_meas_raw: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ13
        i_meas_valid |=> o_meas_q == $past(i_meas_data)) else $error("measurement altered");
    // RQ7 operation start
    a_op_start: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ7
        state_q == CMPM_ST_STANDBY && i_enable && i_evt.op_start && !i_evt.sleep_cmd && !i_evt.wdog_timeout
        |=> state_q == CMPM_ST_ACTIVE) else $error("active not entered");
    // RQ7 operation end
    a_op_done: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ7
        state_q == CMPM_ST_ACTIVE && i_enable && i_evt.op_done && !i_evt.sleep_cmd && !i_evt.wdog_timeout
        |=> state_q == CMPM_ST_STANDBY) else $error("standby not resumed");

    // RQ3 timed work in sleep
    sequence s_sleep_tick;
        state_q == CMPM_ST_SLEEP && i_enable && !i_evt.comms_activity && i_evt.timed_tick;
    endsequence
    sequence s_work_done;
        state_q == CMPM_ST_SLPWORK && i_enable && !i_evt.comms_activity && i_evt.timed_done;
    endsequence
    a_sleep_work: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ3
        s_sleep_tick |=> state_q == CMPM_ST_SLPWORK) else $error("timed work not started in sleep");
    a_work_return: assert property (@(posedge i_core_clk) disable iff (i_srst) // RQ3
        s_work_done |=> state_q == CMPM_ST_SLEEP) else $error("sleep not resumed after timed work");
endmodule

// >>> test/cmpm_host.sv
// host-side command source facing the power mode sequencer.
// assumes the bench calls send just after a rising edge.
`timescale 1ns/1ns
module cmpm_host
(
    input wire logic i_core_clk,
    output cmpm_pkg::cmpm_evt_t o_evt
);
    import cmpm_pkg::*;
    initial o_evt = '0;
    // one-cycle command pulse
    task automatic send(input cmpm_evt_t e);
        o_evt = e;
        @(posedge i_core_clk);
        #1 o_evt = '0;
        // one idle edge so a following send never re-drives in this time step
        @(posedge i_core_clk);
        #1;
    endtask
endmodule

// >>> test/cmpm_top_tb.sv
// self-checking bench for the power mode sequencer.
// assumes the host model drives all events; masks start open and t_balance_modes narrows them.
`timescale 1ns/1ns
module cmpm_top_tb;
    import cmpm_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic enable = 1'b1;
    cmpm_evt_t evt;
    logic [11:0] demand = 12'h000;
    logic [1:0] bal_mode = CMPM_BAL_MANUAL;
    logic [11:0] timed_mask = 12'hfff;
    logic [11:0] auto_mask = 12'hfff;
    logic fault_raw = 1'b0;
    logic meas_valid = 1'b0;
    logic [13:0] meas_data = 14'h0000;
    cmpm_state_t state;
    cmpm_pwr_t pwr;
    logic [11:0] pin;
    logic [11:0] src;
    logic reload;
    logic fault;
    logic [13:0] meas_q;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2 core_clk = ~core_clk;

    cmpm_host i_cmpm_host (.i_core_clk(core_clk), .o_evt(evt));

    cmpm_top i_cmpm_top (.i_core_clk(core_clk), .i_srst(srst), .i_enable(enable), .i_evt(evt),
        .i_bal_mode(bal_mode), .i_bal_demand(demand), .i_bal_timed_mask(timed_mask),
        .i_bal_auto_mask(auto_mask), .i_fault_raw(fault_raw), .i_meas_valid(meas_valid),
        .i_meas_data(meas_data), .o_state(state), .o_pwr(pwr), .o_balance_gate_drive_output(pin),
        .o_gate_src_on(src), .o_factory_reload(reload), .o_fault(fault), .o_meas_q(meas_q));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic finish_test();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic t_wake_reset();
        check(32'(reload), 32'h1);
        srst = 1'b0;
        step(1);
        check(32'(reload), 32'h0);
        check(32'(state), 32'(CMPM_ST_STANDBY));
        check(32'({pwr.main_reg_en, pwr.ext_sw_en}), 32'h3);
    endtask

    task automatic t_active_balance_sleep();
        i_cmpm_host.send(cmpm_evt_t'(7'h08));
        check(32'(state), 32'(CMPM_ST_ACTIVE));
        demand = 12'hfff;
        step(1);
        check(32'(src), 32'h0fff);
        check(32'(pin), 32'h0e00);
        i_cmpm_host.send(cmpm_evt_t'(7'h40));
        check(32'(state), 32'(CMPM_ST_SLEEP));
        check(32'(src), 32'h0000);
        check(32'(pin), 32'h01ff);
        check(32'({pwr.main_reg_en, pwr.ext_sw_en}), 32'h0);
        check(32'({pwr.analog_bias_en, pwr.comms_in_en, pwr.slow_osc_en, pwr.regs_en}), 32'h7);
        i_cmpm_host.send(cmpm_evt_t'(7'h10));
        check(32'(state), 32'(CMPM_ST_STANDBY));
        step(1);
        check(32'(src), 32'h0fff);
        demand = 12'h000;
    endtask

    task automatic t_wdog_and_race();
        i_cmpm_host.send(cmpm_evt_t'(7'h20));
        check(32'(state), 32'(CMPM_ST_SLEEP));
        i_cmpm_host.send(cmpm_evt_t'(7'h10));
        step(3);
        check(32'(state), 32'(CMPM_ST_STANDBY));
        i_cmpm_host.send(cmpm_evt_t'(7'h48));
        check(32'(state), 32'(CMPM_ST_SLEEP));
        i_cmpm_host.send(cmpm_evt_t'(7'h10));
        check(32'(state), 32'(CMPM_ST_STANDBY));
    endtask

    task automatic t_shutdown();
        demand = 12'h0fff;
        enable = 1'b0;
        step(1);
        check(32'(state), 32'(CMPM_ST_SHUTDOWN));
        i_cmpm_host.send(cmpm_evt_t'(7'h08));
        step(4);
        check(32'(state), 32'(CMPM_ST_SHUTDOWN));
        check(32'(src), 32'h0000);
        check(32'({pwr.main_reg_en, pwr.digital_core_en, pwr.sleep_reg_en, pwr.in_buf_en}), 32'h7);
        check(32'({pwr.ext_sw_en, pwr.analog_bias_en}), 32'h0);
        enable = 1'b1;
        step(1);
        check(32'(state), 32'(CMPM_ST_STANDBY));
        check(32'(reload), 32'h0);
        check(32'(src), 32'h0fff);
        demand = 12'h000;
    endtask

    task automatic t_balance_modes();
        demand = 12'hfff;
        timed_mask = 12'h0f0;
        auto_mask = 12'h00f;
        bal_mode = CMPM_BAL_TIMED;
        step(1);
        check(32'(src), 32'h00f0);
        bal_mode = CMPM_BAL_AUTO;
        step(1);
        check(32'(src), 32'h000f);
        bal_mode = 2'h3;
        step(1);
        check(32'(src), 32'h0fff);
        bal_mode = CMPM_BAL_TIMED;
        i_cmpm_host.send(cmpm_evt_t'(7'h08));
        i_cmpm_host.send(cmpm_evt_t'(7'h04));
        check(32'(state), 32'(CMPM_ST_STANDBY));
        check(32'(src), 32'h00f0);
        i_cmpm_host.send(cmpm_evt_t'(7'h40));
        i_cmpm_host.send(cmpm_evt_t'(7'h02));
        check(32'(state), 32'(CMPM_ST_SLPWORK));
        check(32'(src), 32'h0000);
        check(32'(pwr.main_reg_en), 32'h0);
        i_cmpm_host.send(cmpm_evt_t'(7'h01));
        check(32'(state), 32'(CMPM_ST_SLEEP));
        i_cmpm_host.send(cmpm_evt_t'(7'h12));
        check(32'(state), 32'(CMPM_ST_STANDBY));
        demand = 12'h000;
        bal_mode = CMPM_BAL_MANUAL;
    endtask

    task automatic t_fault_meas();
        fault_raw = 1'b1;
        step(3);
        check(32'(fault), 32'h0);
        step(2);
        check(32'(fault), 32'h1);
        fault_raw = 1'b0;
        meas_valid = 1'b1;
        meas_data = 14'h3a5c;
        step(1);
        meas_valid = 1'b0;
        meas_data = 14'h0000;
        check(32'(meas_q), 32'h3a5c);
        step(5);
        check(32'(fault), 32'h0);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            finish_test();
        end
    end

    initial
    begin
        step(20);
        t_wake_reset();
        t_active_balance_sleep();
        t_wdog_and_race();
        t_shutdown();
        t_fault_meas();
        t_balance_modes();
        finish_test();
    end
endmodule
